// ---- logic/flow_avg.v ----
// flow sample averaging, sticky flags, temperature hold and new-data line
// Function
// [RQ1] start command runs sampling every 0.5 ms
// [RQ2] readout value averages all samples since last read
// [RQ3] under 100 ms use arithmetic mean
// [RQ4] after 100 ms exponential smoothing, alpha 0.0125
// [RQ5] smoothing seeded from mean at 100 ms
// [RQ6] flag bit 5 set while smoothing
// [RQ7] host should read within 100 ms
// [RQ8] temperature sampled about every 12 ms
// [RQ9] temperature not averaged, latest returned
// [RQ10] high-flow and air flags sticky until read
// [RQ11] sample over limit sets flag bit 1
// [RQ12] bit 1 holds until flag read clears it
// [RQ13] air flag only for large bubbles/empty channel
// [RQ14] host should not rely on air flag
// [RQ15] bus answers within 25 ms of power-up
// [RQ16] idle after reset until start command
// [RQ17] first result about 12 ms after start
// [RQ18] host waits 50 ms warm-up for accuracy
// [RQ19] new-data line inactive until enabled
// [RQ20] enabled new-data line low when data new
// [RQ21] new-data line goes high on flow read
// [RQ22] flag bit 0 air, bit 1 high flow, bit 5 smoothing, others reserved
// [RQ23] flow read restarts averaging and timer
// [RQ24] reserved flag bits read zero
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "flow_avg_defs.vh"
module flow_avg #(
   parameter [31:0] SAMPLE_CYC = `SAMPLE_US * `CLK_MHZ,
   parameter [31:0] TEMP_CYC = `TEMP_US * `CLK_MHZ,
   parameter [31:0] FIRST_CYC = `FIRST_US * `CLK_MHZ,
   parameter [31:0] MEAN_CYC = `MEAN_US * `CLK_MHZ,
   parameter [31:0] READY_CYC = `READY_US * `CLK_MHZ
) (
   // clock, reset, enable
   input wire clock,
   input wire reset_n,
   input wire clk_en,
   // measurement front end, asynchronous
   input wire [15:0] flow_sample,
   input wire [15:0] temp_sample,
   input wire high_flow_det,
   input wire air_det,
   // avalon-mm slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   // new-data interrupt, active low
   output reg new_data_irq_n
);
   // sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_INIT = 2'h1;
   localparam ST_RUN = 2'h2;

   // two-stage synchronisers, one per front-end bit; a multi-bit sample may
   // tear for a cycle while it changes, so the front end must hold each value
   // well beyond the two-clock delay
   wire [33:0] async_in = {air_det, high_flow_det, temp_sample, flow_sample};
   wire [33:0] sync2_bus;
   genvar gi;
   generate
      for (gi = 0; gi < 34; gi = gi + 1) begin : g_sync
         reg s1_ff;
         reg s2_ff;
         always @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
            end else if (clk_en) begin
               s1_ff <= async_in[gi];
               s2_ff <= s1_ff;
            end
         end
         assign sync2_bus[gi] = s2_ff;
      end
   endgenerate
   wire signed [15:0] s_flow = sync2_bus[15:0];
   wire [15:0] s_temp = sync2_bus[31:16];
   wire s_high = sync2_bus[32];
   wire s_air = sync2_bus[33];

   // sequencer and power-up
   reg [1:0] state_ff;
   reg [31:0] samp_cnt_ff;
   reg [31:0] temp_cnt_ff;
   reg [31:0] ready_cnt_ff;
   reg ready_ff;

   // host-written control bits
   reg [7:0] ctrl_ff;

   // averaging state; the window counter restarts on every flow read
   reg [31:0] win_cnt_ff;
   reg signed [31:0] acc_ff;
   reg [15:0] n_ff;
   reg signed [31:0] ema_ff;
   reg exp_ff;

   // held results, sticky flags and new-data status
   reg signed [15:0] flow_out_ff;
   reg [15:0] temp_ff;
   reg high_ff;
   reg air_ff;
   reg new_ff;

   // register decode, shared by the bus strobes
   function addr_is;
      input [3:0] a;
      input [3:0] reg_off;
      begin
         addr_is = (a == reg_off);
      end
   endfunction

   // bus decode, one-cycle wait so the answer is always registered; while
   // not ready a request simply stalls, so the master needs no power-up delay
   wire req = (read | write) & ready_ff;
   wire acc_go = req & waitrequest & clk_en;
   wire wr_ctrl = acc_go & write & addr_is(address, `REG_CONTROL) & byteenable[0];
   wire rd_flow = acc_go & read & addr_is(address, `REG_FLOW);
   wire rd_flag = acc_go & read & addr_is(address, `REG_FLAGS);
   wire run_bit = ctrl_ff[`CTRL_RUN];
   wire irq_en = ctrl_ff[`CTRL_IRQ_EN];

   // signed division helper for mean
   function signed [15:0] mean_of;
      input signed [31:0] sum;
      input [15:0] cnt;
      reg signed [31:0] q;
      begin
         q = 32'sh0;
         if (cnt != 16'h0)
            q = sum / $signed({16'h0, cnt});
         mean_of = q[15:0];
      end
   endfunction

   // one smoothing step in 16.16 fixed point, alpha = 1/80; the difference
   // is taken one bit wider so opposite full-scale values cannot wrap
   function signed [31:0] smooth;
      input signed [31:0] prev;
      input signed [31:0] samp;
      reg signed [32:0] diff;
      begin
         diff = $signed({samp[31], samp}) - $signed({prev[31], prev});
         diff = diff / `ALPHA_DIV;
         smooth = prev + diff[31:0];
      end
   endfunction

   // ticks fire only while running; the window counts run time only
   wire samp_tick = (state_ff == ST_RUN) & (samp_cnt_ff >= SAMPLE_CYC - 32'h1);
   wire temp_tick = (state_ff == ST_RUN) & (temp_cnt_ff >= TEMP_CYC - 32'h1);
   wire win_done = win_cnt_ff >= MEAN_CYC - 32'h1;
   // seed and sample in 16.16 fixed point
   wire signed [15:0] mean16 = mean_of(acc_ff, n_ff);
   wire signed [31:0] seed_fx = {mean16, 16'h0};
   wire signed [31:0] samp_fx = {s_flow, 16'h0};
   wire signed [31:0] samp_ext = {{16{s_flow[15]}}, s_flow};
   wire signed [31:0] ema_next = smooth(ema_ff, samp_fx);
   wire signed [31:0] ema_first = smooth(seed_fx, samp_fx);

   // power-up ready counter; the bus stalls until it expires, so a host that
   // polls early only sees a long wait, never a wrong answer; the counter
   // stops once ready
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ready_cnt_ff <= 32'h0;
         ready_ff <= 1'b0;
      end else if (clk_en && !ready_ff) begin
         ready_cnt_ff <= ready_cnt_ff + 32'h1;
         if (ready_cnt_ff >= READY_CYC - 32'h1)
            ready_ff <= 1'b1; // RQ15
      end
   end

   // read mux; unmapped offsets answer zero, reserved flag bits read zero
   function [31:0] read_word;
      input [3:0] a;
      input [7:0] ctrl;
      input [15:0] flow;
      input [15:0] temp;
      input [2:0] flags;
      begin
         case (a)
            `REG_CONTROL: read_word = {24'h0, ctrl};
            `REG_FLOW: read_word = {{16{flow[15]}}, flow}; // RQ2
            `REG_TEMP: read_word = {16'h0, temp}; // RQ9
            // bits 2-4 and 6-31 read zero
            `REG_FLAGS: read_word = {26'h0, flags[2], 3'h0, flags[1:0]}; // RQ22 RQ24
            default: read_word = 32'h0;
         endcase
      end
   endfunction

   // answer handshake: low for exactly the cycle after a request is taken,
   // so back-to-back requests always cost two cycles each
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         waitrequest <= 1'b1;
      else if (clk_en)
         waitrequest <= ~acc_go; // RQ15
   end

   // control register; only byte 0 holds bits, writes elsewhere are
   // ignored so a stray write cannot start or stop a run
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         ctrl_ff <= `CTRL_RESET; // RQ16
      else if (wr_ctrl)
         ctrl_ff <= writedata[7:0];
   end

   // read data, captured at the taken edge and held until the next read
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         readdata <= 32'h0;
      end else if (acc_go && read) begin
         readdata <= read_word(address, ctrl_ff, flow_out_ff, temp_ff, {exp_ff, high_ff, air_ff});
      end
   end

   // measurement sequencer: idle until run is set, a start-up delay before
   // the first result, then one sample tick every sample period and one
   // temperature tick every temperature period
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         samp_cnt_ff <= 32'h0;
         temp_cnt_ff <= 32'h0;
      end else if (clk_en) begin
         case (state_ff)
            ST_IDLE: begin
               samp_cnt_ff <= 32'h0;
               temp_cnt_ff <= 32'h0;
               if (run_bit)
                  state_ff <= ST_INIT; // RQ1
            end
            ST_INIT: begin
               samp_cnt_ff <= samp_cnt_ff + 32'h1;
               if (!run_bit) begin
                  state_ff <= ST_IDLE;
               end else if (samp_cnt_ff >= FIRST_CYC - 32'h1) begin
                  state_ff <= ST_RUN; // RQ17
                  samp_cnt_ff <= SAMPLE_CYC - 32'h1;
                  temp_cnt_ff <= TEMP_CYC - 32'h1;
               end
            end
            ST_RUN: begin
               if (!run_bit)
                  state_ff <= ST_IDLE;
               samp_cnt_ff <= samp_tick ? 32'h0 : samp_cnt_ff + 32'h1; // RQ1
               temp_cnt_ff <= temp_tick ? 32'h0 : temp_cnt_ff + 32'h1; // RQ8
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // averaging: mean for the first 100 ms, then exponential smoothing;
   // past the window a late reader gets roughly the last 40 ms of flow (80 samples)
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         acc_ff <= 32'sh0;
         n_ff <= 16'h0;
         ema_ff <= 32'sh0;
         exp_ff <= 1'b0;
         win_cnt_ff <= 32'h0;
         flow_out_ff <= 16'sh0;
      end else if (clk_en) begin
         if (rd_flow) begin
            // restart the window; a sample on the read edge opens the new one
            // rather than being lost with the old sum
            exp_ff <= 1'b0;
            win_cnt_ff <= 32'h0;
            if (samp_tick) begin
               acc_ff <= samp_ext; // RQ23 RQ2
               n_ff <= 16'h1;
               flow_out_ff <= s_flow;
            end else begin
               acc_ff <= 32'sh0; // RQ23
               n_ff <= 16'h0;
            end
         end else if (state_ff != ST_RUN) begin
            // stopped: the 100 ms window and the smoothing flag start over
            exp_ff <= 1'b0;
            win_cnt_ff <= 32'h0;
         end else begin
            if (!win_done)
               win_cnt_ff <= win_cnt_ff + 32'h1;
            if (win_done && !exp_ff) begin
               exp_ff <= 1'b1; // RQ6
               // seed from the mean; a sample on this edge is applied at once
               if (samp_tick) begin
                  ema_ff <= ema_first; // RQ5 RQ4
                  flow_out_ff <= ema_first[31:16];
               end else begin
                  ema_ff <= seed_fx; // RQ5
               end
            end else if (samp_tick && exp_ff) begin
               ema_ff <= ema_next; // RQ4
               flow_out_ff <= ema_next[31:16]; // RQ4
            end else if (samp_tick) begin
               // mean kept live so a read always sees the current value
               acc_ff <= acc_ff + samp_ext; // RQ3
               n_ff <= n_ff + 16'h1;
               flow_out_ff <= mean_of(acc_ff + samp_ext, n_ff + 16'h1); // RQ2 RQ3
            end
         end
      end
   end

   // temperature hold: the latest reading only, never averaged, so a
   // reader sees at most one temperature period of age while the sequencer runs
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         temp_ff <= 16'h0;
      else if (clk_en && temp_tick)
         temp_ff <= s_temp; // RQ8 RQ9
   end

   // high-flow flag: an event in the read cycle wins over the clear,
   // so an event is never lost between two reads
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         high_ff <= 1'b0;
      else if (clk_en) begin
         if (samp_tick && s_high)
            high_ff <= 1'b1; // RQ11 RQ10
         else if (rd_flag)
            high_ff <= 1'b0; // RQ12
      end
   end

   // air flag, sampled at the temperature rate; the front end raises it only
   // for big bubbles or an empty channel, so it is a hint, not a safeguard
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         air_ff <= 1'b0;
      else if (clk_en) begin
         if (temp_tick && s_air)
            air_ff <= 1'b1; // RQ13 RQ10
         else if (rd_flag)
            air_ff <= 1'b0; // RQ10
      end
   end

   // new-data status: set per sample, cleared by a flow read; a sample in
   // the read cycle is new to the reader, so the set wins
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         new_ff <= 1'b0;
      else if (clk_en) begin
         if (samp_tick)
            new_ff <= 1'b1;
         else if (rd_flow)
            new_ff <= 1'b0; // RQ21
      end
   end

   // new-data line: a flow read always lifts it for at least one cycle; a
   // sample on that same edge keeps the status set and pulls it low again
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n)
         new_data_irq_n <= 1'b1;
      else if (clk_en)
         new_data_irq_n <= ~(irq_en & (new_ff | samp_tick) & ~rd_flow); // RQ19 RQ20 RQ21
   end
endmodule // flow_avg
`default_nettype wire

// ---- logic/flow_avg_defs.vh ----
// constants for the flow averaging and flag block
`ifndef FLOW_AVG_DEFS_VH
`define FLOW_AVG_DEFS_VH
// register byte offsets
`define REG_CONTROL 4'h0
`define REG_FLOW 4'h4
`define REG_TEMP 4'h8
`define REG_FLAGS 4'hc
// control register fields
`define CTRL_RUN 0
`define CTRL_IRQ_EN 1
`define CTRL_RESET 8'h00
// flag word fields
`define FLAG_AIR 0
`define FLAG_HIGH 1
`define FLAG_EXP 5
// timing, in microseconds, and the clock in MHz
`define CLK_MHZ 25
`define SAMPLE_US 500
`define TEMP_US 12000
`define FIRST_US 12000
`define MEAN_US 100000
`define READY_US 25000
// alpha = 0.0125 = 1/80
`define ALPHA_DIV 80
`endif

// ---- tb/flow_avg_assertions.sv ----
// checker for the flow averaging block ports
`timescale 1ns/100ps
`default_nettype none
module flow_avg_assertions #(
   parameter [31:0] READY_CYC = 32'h1
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register bus
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // new-data line
   input wire logic new_data_irq_n
);
   logic [31:0] cnt_ff;
   logic [1:0] ctrl_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // cycles since release, saturating; mirror of run and enable bits
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 32'h0;
         ctrl_ff <= 2'h0;
      end else begin
         if (cnt_ff < READY_CYC) cnt_ff <= cnt_ff + 32'h1;
         if (write && !waitrequest && address == 4'h0) ctrl_ff <= writedata[1:0];
      end
   end
   AST_READY: assert property (cnt_ff + 32'h1 < READY_CYC |-> waitrequest)
      else $error("bus answered before ready");
   AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   AST_TAKE: assert property ($fell(waitrequest) |-> $past(read || write))
      else $error("answer without request");
   AST_HOLD: assert property (waitrequest |-> $stable(readdata))
      else $error("read data moved between reads");
   AST_UNMAPPED: assert property (!waitrequest && read && address[1:0] != 2'h0
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   AST_RSVD: assert property (!waitrequest && read && address == 4'hc
      |-> (readdata & 32'hffffffdc) == 32'h0) else $error("reserved flag bits set");
   AST_IDLE_EXP: assert property (!ctrl_ff[0] && $past(!ctrl_ff[0]) && !waitrequest
      && read && address == 4'hc |-> !readdata[5]) else $error("smoothing flag while idle");
   AST_IRQ_OFF: assert property (!ctrl_ff[1] && !$past(ctrl_ff[1]) |-> new_data_irq_n)
      else $error("new-data line low while disabled");
   AST_IRQ_CLR: assert property (!waitrequest && read && address == 4'h4
      |-> new_data_irq_n) else $error("new-data line not cleared by flow read");
   cover property (!waitrequest && read && address == 4'hc && readdata[5]);
   cover property (!waitrequest && read && address == 4'hc && readdata[1]);
   cover property ($fell(new_data_irq_n));
endmodule // flow_avg_assertions
bind flow_avg flow_avg_assertions #(.READY_CYC(READY_CYC)) chk (.clock(clock),
   .reset_n(reset_n), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .new_data_irq_n(new_data_irq_n));
`default_nettype wire

// ---- tb/host_master.sv ----
// host model: register bus master
`timescale 1ns/100ps
`default_nettype none
module host_master (
   // clock
   input wire logic clock,
   // register bus
   output logic [3:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   output logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   // quiet bus; no start issued until the caller asks
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
   end
   // one transfer, held until waitrequest sampled low; bound avoids a hang
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic ok);
      int n;
      n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 3000);
      q = readdata;
      ok = (waitrequest === 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask
endmodule // host_master
`default_nettype wire

// ---- tb/test_flow_sample_averaging_and_flags.sv ----
// bench for the flow averaging block
`timescale 1ns/100ps
`default_nettype none
module test_flow_sample_averaging_and_flags;
   localparam int SMP = 32'h14;
   localparam int TMP = 32'h64;
   localparam int AVG = 32'h190;
   logic clock, reset_n, high_flow_det, air_det, ok;
   logic [15:0] flow_sample, temp_sample;
   logic [31:0] q, ev;
   wire [3:0] address, byteenable;
   wire read, write, waitrequest, new_data_irq_n;
   wire [31:0] writedata, readdata;
   int fails, n_compared, seed, v, t, i;
   flow_avg #(.SAMPLE_CYC(SMP), .TEMP_CYC(TMP), .FIRST_CYC(32'h32), .MEAN_CYC(AVG),
      .READY_CYC(32'ha)) uut (.clock(clock), .reset_n(reset_n), .clk_en(1'b1),
      .flow_sample(flow_sample), .temp_sample(temp_sample), .high_flow_det(high_flow_det),
      .air_det(air_det), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .new_data_irq_n(new_data_irq_n));
   host_master host (.clock(clock), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest));
   // compare tasks, one per kind of result
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp || ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_irq(input logic exp);
      n_compared++;
      if (new_data_irq_n !== exp) begin
         fails++;
         $display("CHECK FAILED %0t new-data line %b", $time, new_data_irq_n);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, q, ok);
      chk_word(q, exp);
   endtask
   task automatic wr(input logic [31:0] d);
      host.xfer(1'b1, 4'h0, d, q, ok);
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t write not answered", $time);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // 25 MHz clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // constant random flow: mean and smoothed value both equal it exactly
   initial begin
      seed = 46135;
      fails = 0;
      n_compared = 0;
      v = $random(seed);
      t = $random(seed);
      ev = {{16{v[15]}}, v[15:0]};
      reset_n = 1'b0;
      flow_sample = v[15:0];
      temp_sample = t[15:0];
      high_flow_det = 1'b0;
      air_det = 1'b0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      rd(4'hc, 32'h0);
      rd(4'h2, 32'h0);
      rd(4'h0, 32'h0);
      wr(32'h1);
      for (i = 0; i < 32'h32 + 3 * SMP; i++) begin
         @(posedge clock);
         chk_irq(1'b1);
      end
      rd(4'h4, ev);
      rd(4'h8, {16'h0, t[15:0]});
      t = $random(seed);
      temp_sample <= t[15:0];
      high_flow_det <= 1'b1;
      air_det <= 1'b1;
      repeat (TMP + 10) @(posedge clock);
      high_flow_det <= 1'b0;
      air_det <= 1'b0;
      repeat (TMP + 10) @(posedge clock);
      rd(4'h8, {16'h0, t[15:0]});
      rd(4'hc, 32'h3);
      rd(4'hc, 32'h0);
      wr(32'h3);
      rd(4'h4, ev);
      for (i = 0; i < 2 * SMP && new_data_irq_n !== 1'b0; i++) @(posedge clock);
      chk_irq(1'b0);
      rd(4'h4, ev);
      repeat (2) @(posedge clock);
      chk_irq(1'b1);
      // late read on purpose, past the smoothing point
      repeat (AVG + 2 * SMP) @(posedge clock);
      rd(4'hc, 32'h20);
      rd(4'h4, ev);
      rd(4'hc, 32'h0);
      wr(32'h0);
      rd(4'hc, 32'h0);
      end_sim;
   end
endmodule // test_flow_sample_averaging_and_flags
`default_nettype wire
